// file: hdl/iscr_regs.svh
// Offsets, field positions, defaults, update code and frame bit count of the sensor setup registers
`ifndef ISCR_REGS_SVH
`define ISCR_REGS_SVH
`define ISCR_ADDR_SETUP_A 3'h0
`define ISCR_ADDR_SETUP_B 3'h1
`define ISCR_UPDATE_CODE 4'h9
`define ISCR_FRAME_BITS 5'h18
`define ISCR_RST_SETUP_A 16'h8095
`define ISCR_RST_SETUP_B 16'h035A
`define ISCR_A_ROWS_RST_HI 15
`define ISCR_A_ROWS_RST_LO 8
`define ISCR_A_VRST_HI 7
`define ISCR_A_VRST_LO 6
`define ISCR_A_RAMP_GAIN_HI 5
`define ISCR_A_RAMP_GAIN_LO 4
`define ISCR_A_RAMP_OFS_HI 3
`define ISCR_A_RAMP_OFS_LO 2
`define ISCR_A_DRIVE_HI 1
`define ISCR_A_DRIVE_LO 0
`define ISCR_B_DELAY_HI 15
`define ISCR_B_DELAY_LO 11
`define ISCR_B_BIAS 10
`define ISCR_B_CDS_GAIN 9
`define ISCR_B_OUT_MODE 8
`define ISCR_B_CLK_SCALE_HI 7
`define ISCR_B_CLK_SCALE_LO 6
`define ISCR_B_CDS_REF_HI 5
`define ISCR_B_CDS_REF_LO 4
`define ISCR_B_CONV_CURR_HI 3
`define ISCR_B_CONV_CURR_LO 2
`define ISCR_B_IDLE 1
`define ISCR_B_HIGH_SPEED 0
`endif

// file: hdl/iscr_pkg.sv
// Types shared by the sensor setup register block
package iscr_pkg;
   typedef enum logic [1:0] {
      ISCR_CLK_DOUBLE = 2'b00,
      ISCR_CLK_NORMAL = 2'b01,
      ISCR_CLK_HALF = 2'b10
   } iscr_clk_scale_t;

   typedef struct packed {
      logic [9:0] rows_in_reset;
      logic [1:0] pix_reset_volt;
      logic [1:0] ramp_gain;
      logic [1:0] ramp_offset;
      logic [1:0] drive_current;
      logic [8:0] delay_rows;
      logic bias_boost;
      logic cds_gain_high;
      logic output_mode;
      iscr_clk_scale_t clk_scale;
      logic [1:0] cds_ref;
      logic [1:0] conv_current;
      logic idle_enable;
      logic high_speed;
   } iscr_cfg_t;
endpackage : iscr_pkg

// file: hdl/iscr_config_regs.sv
// Serial-loaded sensor setup registers and their decoded controls
`timescale 1ns/100ps
`include "iscr_regs.svh"
module iscr_config_regs (
   input wire logic core_clk,
   input wire logic nrst,
   input wire logic config_serial_clk,
   input wire logic config_serial_line,
   input wire logic config_window,
   output iscr_pkg::iscr_cfg_t cfg,
   output logic [2:0] clk_rate_sel,
   output logic write_done
);
   import iscr_pkg::*;

   logic [1:0] sclk_sync_ff;
   logic [1:0] config_serial_line_sync_ff;
   logic [1:0] win_sync_ff;
   logic sclk_prev_ff;
   logic [22:0] shift_ff;
   logic [4:0] count_ff;
   logic [15:0] setup_a_ff;
   logic [15:0] setup_b_ff;
   iscr_cfg_t cfg_ff;
   logic [2:0] rate_ff;
   logic done_ff;
   logic [22:0] nxt_shift;
   logic [4:0] nxt_count;
   logic [15:0] nxt_setup_a;
   logic [15:0] nxt_setup_b;
   iscr_cfg_t nxt_cfg;
   logic [2:0] nxt_rate;
   logic nxt_done;
   logic sclk_rise;

   // Clock scale codes 2 and 3 both halve the clock
   function automatic iscr_clk_scale_t decode_scale(input logic [1:0] code);
      if (code[1]) begin
         decode_scale = ISCR_CLK_HALF;
      end else begin
         decode_scale = iscr_clk_scale_t'(code);
      end
   endfunction : decode_scale

   // Pins are asynchronous to core_clk
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         sclk_sync_ff <= 2'h0;
         config_serial_line_sync_ff <= 2'h0;
         win_sync_ff <= 2'h0;
         sclk_prev_ff <= 1'b0;
      end else begin
         sclk_sync_ff <= {sclk_sync_ff[0], config_serial_clk};
         config_serial_line_sync_ff <= {config_serial_line_sync_ff[0], config_serial_line};
         win_sync_ff <= {win_sync_ff[0], config_window};
         sclk_prev_ff <= sclk_sync_ff[1];
      end
   end

   assign sclk_rise = sclk_sync_ff[1] && !sclk_prev_ff;

   always_comb begin
      nxt_shift = shift_ff;
      nxt_count = count_ff;
      nxt_setup_a = setup_a_ff;
      nxt_setup_b = setup_b_ff;
      nxt_done = 1'b0;
      if (!win_sync_ff[1]) begin
         // Outside the window a partial word is dropped
         nxt_count = 5'h0;
         nxt_shift = 23'h0;
      end else if (sclk_rise) begin
         nxt_shift = {shift_ff[21:0], config_serial_line_sync_ff[1]};
         if (count_ff == 5'h3 && {shift_ff[2:0], config_serial_line_sync_ff[1]} != `ISCR_UPDATE_CODE) begin
            // Slide until the update code lines up
            nxt_count = 5'h3;
         end else if (count_ff == `ISCR_FRAME_BITS - 5'h1) begin
            // 24th edge carries the separator bit; load then clear
            nxt_count = 5'h0;
            nxt_shift = 23'h0;
            if (shift_ff[18:16] == `ISCR_ADDR_SETUP_A) begin
               nxt_setup_a = shift_ff[15:0];
               nxt_done = 1'b1;
            end else if (shift_ff[18:16] == `ISCR_ADDR_SETUP_B) begin
               nxt_setup_b = shift_ff[15:0];
               nxt_done = 1'b1;
            end
         end else begin
            nxt_count = count_ff + 5'h1;
         end
      end
   end

   always_comb begin
      nxt_cfg.rows_in_reset = {1'b0, setup_a_ff[`ISCR_A_ROWS_RST_HI:`ISCR_A_ROWS_RST_LO], 1'b0} + 10'h002;
      nxt_cfg.pix_reset_volt = setup_a_ff[`ISCR_A_VRST_HI:`ISCR_A_VRST_LO];
      nxt_cfg.ramp_gain = setup_a_ff[`ISCR_A_RAMP_GAIN_HI:`ISCR_A_RAMP_GAIN_LO];
      nxt_cfg.ramp_offset = setup_a_ff[`ISCR_A_RAMP_OFS_HI:`ISCR_A_RAMP_OFS_LO];
      nxt_cfg.drive_current = setup_a_ff[`ISCR_A_DRIVE_HI:`ISCR_A_DRIVE_LO];
      nxt_cfg.delay_rows = {setup_b_ff[`ISCR_B_DELAY_HI:`ISCR_B_DELAY_LO], 4'h0} + 9'h2;
      nxt_cfg.bias_boost = setup_b_ff[`ISCR_B_BIAS];
      nxt_cfg.cds_gain_high = setup_b_ff[`ISCR_B_CDS_GAIN];
      nxt_cfg.output_mode = setup_b_ff[`ISCR_B_OUT_MODE];
      nxt_cfg.clk_scale = decode_scale(setup_b_ff[`ISCR_B_CLK_SCALE_HI:`ISCR_B_CLK_SCALE_LO]);
      // No clamp: host owns the offset-versus-reference spacing
      nxt_cfg.cds_ref = setup_b_ff[`ISCR_B_CDS_REF_HI:`ISCR_B_CDS_REF_LO];
      nxt_cfg.conv_current = setup_b_ff[`ISCR_B_CONV_CURR_HI:`ISCR_B_CONV_CURR_LO];
      nxt_cfg.idle_enable = setup_b_ff[`ISCR_B_IDLE];
      nxt_cfg.high_speed = setup_b_ff[`ISCR_B_HIGH_SPEED];
      // Index 0..5: double/normal/half, plus 3 when high speed
      nxt_rate = {1'b0, nxt_cfg.clk_scale} + (nxt_cfg.high_speed ? 3'h3 : 3'h0);
   end

   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         shift_ff <= 23'h0;
         count_ff <= 5'h0;
         setup_a_ff <= `ISCR_RST_SETUP_A;
         setup_b_ff <= `ISCR_RST_SETUP_B;
         cfg_ff <= '0;
         rate_ff <= 3'h1;
         done_ff <= 1'b0;
      end else begin
         shift_ff <= nxt_shift;
         count_ff <= nxt_count;
         setup_a_ff <= nxt_setup_a;
         setup_b_ff <= nxt_setup_b;
         cfg_ff <= nxt_cfg;
         rate_ff <= nxt_rate;
         done_ff <= nxt_done;
      end
   end

   assign cfg = cfg_ff;
   assign clk_rate_sel = rate_ff;
   assign write_done = done_ff;

   a_done_loads: assert property (@(posedge core_clk) disable iff (!nrst)
      nxt_done |=> (setup_a_ff == $past(shift_ff[15:0]) || setup_b_ff == $past(shift_ff[15:0])))
      else $error("write_done without register load");
   a_no_write_outside: assert property (@(posedge core_clk) disable iff (!nrst)
      !win_sync_ff[1] |=> $stable(setup_a_ff) && $stable(setup_b_ff))
      else $error("register changed outside window");
   a_rows_reset: assert property (@(posedge core_clk) disable iff (!nrst)
      nrst |=> cfg.rows_in_reset == {1'b0, $past(setup_a_ff[15:8]), 1'b0} + 10'h002)
      else $error("rows in reset decode wrong");
   a_delay_rows: assert property (@(posedge core_clk) disable iff (!nrst)
      nrst |=> cfg.delay_rows == {$past(setup_b_ff[15:11]), 4'h0} + 9'h002)
      else $error("delay rows decode wrong");
   a_half_clock: assert property (@(posedge core_clk) disable iff (!nrst)
      setup_b_ff[7] |=> cfg.clk_scale == ISCR_CLK_HALF)
      else $error("clock scale code 2/3 not halved");
   a_rate_index: assert property (@(posedge core_clk) disable iff (!nrst)
      nrst |=> clk_rate_sel == ({1'b0, ($past(setup_b_ff[7]) ? 2'h2 : $past(setup_b_ff[7:6]))}
         + ($past(setup_b_ff[0]) ? 3'h3 : 3'h0)))
      else $error("clock rate index wrong");
   a_reset_dflt: assert property (@(posedge core_clk)
      !nrst |=> setup_a_ff == `ISCR_RST_SETUP_A && setup_b_ff == `ISCR_RST_SETUP_B)
      else $error("reset defaults not loaded");
   a_fields_b: assert property (@(posedge core_clk) disable iff (!nrst)
      nrst |=> {cfg.bias_boost, cfg.cds_gain_high, cfg.cds_ref, cfg.conv_current, cfg.idle_enable, cfg.high_speed}
         == {$past(setup_b_ff[10:9]), $past(setup_b_ff[5:0])})
      else $error("setup B field decode wrong");
   a_fields_a: assert property (@(posedge core_clk) disable iff (!nrst)
      nrst |=> {cfg.pix_reset_volt, cfg.ramp_gain, cfg.ramp_offset, cfg.drive_current} == $past(setup_a_ff[7:0]))
      else $error("setup A field decode wrong");
   a_done_single: assert property (@(posedge core_clk) disable iff (!nrst)
      write_done |=> !write_done)
      else $error("write_done longer than one cycle");
   a_load_code: assert property (@(posedge core_clk) disable iff (!nrst)
      nxt_done |-> shift_ff[22:19] == `ISCR_UPDATE_CODE)
      else $error("load without update code");
   a_addr_refused: assert property (@(posedge core_clk) disable iff (!nrst)
      sclk_rise && win_sync_ff[1] && count_ff == 5'h17 && shift_ff[18:17] != 2'h0 |-> !nxt_done)
      else $error("unimplemented address loaded");
   a_count_bound: assert property (@(posedge core_clk) disable iff (!nrst)
      count_ff < `ISCR_FRAME_BITS)
      else $error("bit counter beyond frame");
   a_win_clears: assert property (@(posedge core_clk) disable iff (!nrst)
      !win_sync_ff[1] |=> count_ff == 5'h0 && shift_ff == 23'h0)
      else $error("partial word kept outside window");
   a_ramp_gain: assert property (@(posedge core_clk) disable iff (!nrst)
      nrst |=> cfg.ramp_gain == $past(setup_a_ff[5:4]))
      else $error("ramp gain decode wrong");
   a_ramp_ofs: assert property (@(posedge core_clk) disable iff (!nrst)
      nrst |=> cfg.ramp_offset == $past(setup_a_ff[3:2]))
      else $error("ramp offset decode wrong");
   a_drive_cur: assert property (@(posedge core_clk) disable iff (!nrst)
      nrst |=> cfg.drive_current == $past(setup_a_ff[1:0]))
      else $error("drive current decode wrong");
   a_cds_gain: assert property (@(posedge core_clk) disable iff (!nrst)
      nrst |=> cfg.cds_gain_high == $past(setup_b_ff[9]))
      else $error("CDS gain decode wrong");
   a_cds_ref: assert property (@(posedge core_clk) disable iff (!nrst)
      nrst |=> cfg.cds_ref == $past(setup_b_ff[5:4]))
      else $error("CDS reference decode wrong");
   a_conv_curr: assert property (@(posedge core_clk) disable iff (!nrst)
      nrst |=> cfg.conv_current == $past(setup_b_ff[3:2]))
      else $error("conversion current decode wrong");
   a_idle_mode: assert property (@(posedge core_clk) disable iff (!nrst)
      nrst |=> cfg.idle_enable == $past(setup_b_ff[1]))
      else $error("idle mode decode wrong");
   a_high_speed: assert property (@(posedge core_clk) disable iff (!nrst)
      nrst |=> cfg.high_speed == $past(setup_b_ff[0]))
      else $error("high speed decode wrong");
endmodule : iscr_config_regs

// file: verification/iscr_host_model.sv
// Host-side serial configuration controller model
`timescale 1ns/100ps
module iscr_host_model (
   output logic config_serial_clk,
   output logic config_serial_line
);
   initial begin
      config_serial_clk = 1'b0;
      config_serial_line = 1'b1;
   end

   // Clock rests low between words; line shows the inverse of the last bit
   task automatic send(input logic [2:0] addr, input logic [15:0] data);
      logic [23:0] frame;
      frame = {4'h9, addr, data, 1'b0};
      #30;
      for (int i = 23; i >= 0; i--) begin
         config_serial_line = frame[i];
         #400 config_serial_clk = 1'b1;
         #400 config_serial_clk = 1'b0;
      end
      config_serial_line = ~frame[0];
   endtask : send

   // Junk bits ahead of a word make the device slide to the code
   task automatic lead(input logic [3:0] junk);
      for (int i = 3; i >= 0; i--) begin
         config_serial_line = junk[i];
         #400 config_serial_clk = 1'b1;
         #400 config_serial_clk = 1'b0;
      end
   endtask : lead
endmodule : iscr_host_model

// file: verification/iscr_config_regs_bench.sv
// Self-checking bench for the sensor setup registers
`timescale 1ns/100ps
module iscr_config_regs_bench;
   import iscr_pkg::*;
   logic core_clk = 1'b0;
   logic nrst = 1'b0;
   logic config_window = 1'b0;
   logic config_serial_clk;
   logic config_serial_line;
   iscr_cfg_t cfg;
   logic [2:0] clk_rate_sel;
   logic write_done;
   logic [7:0] done_cnt = 8'h00;
   logic [15:0] b;
   int err_total = 0;
   int samples_checked = 0;

   always #50 core_clk = ~core_clk;
   always @(posedge core_clk) if (write_done === 1'b1) done_cnt <= done_cnt + 8'h01;

   iscr_host_model u_iscr_host_model (.config_serial_clk(config_serial_clk), .config_serial_line(config_serial_line));
   iscr_config_regs u_iscr_config_regs (.core_clk(core_clk), .nrst(nrst), .config_serial_clk(config_serial_clk),
      .config_serial_line(config_serial_line), .config_window(config_window), .cfg(cfg),
      .clk_rate_sel(clk_rate_sel), .write_done(write_done));

   function automatic iscr_cfg_t dec(input logic [15:0] a, input logic [15:0] r);
      return '{{1'b0, a[15:8], 1'b0} + 10'h002, a[7:6], a[5:4], a[3:2], a[1:0], {r[15:11], 4'h0} + 9'h002,
         r[10], r[9], r[8], iscr_clk_scale_t'(r[7] ? 2'b10 : r[7:6]), r[5:4], r[3:2], r[1], r[0]};
   endfunction : dec

   task automatic print_verdict;
      $display("checks %0d errors %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : print_verdict

   task automatic chk_val(input logic [7:0] got, input logic [7:0] exp);
      samples_checked++;
      if (got !== exp) begin
         err_total++;
         $display("wrong value at %0t: got %h exp %h", $time, got, exp);
      end
   endtask : chk_val

   task automatic chk_cfg(input iscr_cfg_t exp);
      @(negedge core_clk);
      samples_checked++;
      if (cfg !== exp) begin
         err_total++;
         $display("wrong value at %0t: cfg %h exp %h", $time, cfg, exp);
      end
   endtask : chk_cfg

   // Fixed settle covers the pulse latency plus the register update
   task automatic wr(input logic [2:0] addr, input logic [15:0] data, input logic [7:0] pulses);
      logic [7:0] start;
      start = done_cnt;
      u_iscr_host_model.send(addr, data);
      repeat (12) @(posedge core_clk);
      chk_val(done_cnt - start, pulses);
   endtask : wr

   task automatic do_reset;
      @(posedge core_clk);
      nrst <= 1'b0;
      repeat (6) @(posedge core_clk);
      nrst <= 1'b1;
      repeat (4) @(posedge core_clk);
   endtask : do_reset

   initial begin
      #2000000;
      err_total++;
      print_verdict();
   end

   initial begin
      config_window <= 1'b1;
      do_reset();
      chk_cfg(dec(16'h8095, 16'h035A));
      chk_val({5'h00, clk_rate_sel}, 8'h01);
      u_iscr_host_model.lead(4'h0);
      wr(3'h0, 16'hFFDB, 8'h01);
      wr(3'h1, 16'hFDD5, 8'h01);
      chk_cfg(dec(16'hFFDB, 16'hFDD5));
      wr(3'h0, 16'hFEDB, 8'h01);
      chk_cfg(dec(16'hFEDB, 16'hFDD5));
      wr(3'h2, 16'h0000, 8'h00);
      chk_cfg(dec(16'hFEDB, 16'hFDD5));
      @(posedge core_clk) config_window <= 1'b0;
      wr(3'h0, 16'h0000, 8'h00);
      @(posedge core_clk) config_window <= 1'b1;
      chk_cfg(dec(16'hFEDB, 16'hFDD5));
      for (int m = 0; m < 8; m++) begin
         b = {8'h0B, m[1:0], 4'h5, 1'b1, m[2]};
         wr(3'h1, b, 8'h01);
         chk_cfg(dec(16'hFEDB, b));
         chk_val({5'h00, clk_rate_sel}, 8'((m[1] ? 2 : m % 4) + (m[2] ? 3 : 0)));
      end
      do_reset();
      chk_cfg(dec(16'h8095, 16'h035A));
      print_verdict();
   end
endmodule : iscr_config_regs_bench
